// ### verilog/sfc_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_slave (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // Serial pins.
    input  wire logic        chip_select_n_in,
    input  wire logic        sclk_in,
    input  wire logic        si_in,
    output var  logic        so_out,
    output var  logic        so_oe_out,
    // Core status.
    input  wire logic        sleep_in,
    input  wire logic        uv_event_in,
    input  wire logic        spi_reset_in,
    input  wire logic        limp_entry_in,
    input  wire logic [15:0] diag_in,
    input  wire logic        reg_hit_in,
    input  wire logic [14:0] reg_data_in,
    // Core command.
    output var  logic [15:0] frame_out,
    output var  logic        frame_strobe_out,
    output var  logic        fault_flag_out
);
    import sfc_pkg::*;

    logic [2:0]       pins;
    logic [2:0]       pins_d;
    sfc_state_t       state;
    sfc_state_t       next_state;
    logic [15:0]      shift;
    logic [15:0]      next_shift;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             seen_rise;
    logic             next_seen_rise;
    logic             edge_bad;
    logic             next_edge_bad;
    logic             fault;
    logic             next_fault;
    logic             so_q;
    logic             next_so_q;
    logic             oe_q;
    logic             next_oe_q;
    logic [15:0]      answer;
    logic [15:0]      next_answer;
    logic [15:0]      frame_q;
    logic [15:0]      next_frame_q;
    logic             strobe_q;
    logic             next_strobe_q;
    logic             cs_fall;
    logic             cs_rise;
    logic             sck_rise;
    logic             sck_fall;
    logic             count_ok;
    logic [15:0]      std_diag;

    // ========================================================
    // Pin synchronisers and edges.
    sfc_sync #(.WIDTH(3)) u_sync (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .rst_val_in (PIN_RST),
        .async_in   ({si_in, sclk_in, chip_select_n_in}),
        .sync_out   (pins)
    );

    assign cs_fall  = pins_d[0] & ~pins[0];
    assign cs_rise  = ~pins_d[0] & pins[0];
    assign sck_rise = ~pins_d[1] & pins[1];
    assign sck_fall = pins_d[1] & ~pins[1];
    assign count_ok = (cnt >= CNT_MIN) && (cnt[2:0] == 3'h0) &&
                      (cnt != CNT_MAX);
    always_comb begin
        std_diag            = diag_in;
        std_diag[REG_MARK]  = 1'b0;
        std_diag[FAULT_BIT] = fault;
    end

    // ========================================================
    // Frame logic.
    always_comb begin
        next_state     = state;
        next_shift     = shift;
        next_cnt       = cnt;
        next_seen_rise = seen_rise;
        next_edge_bad  = edge_bad;
        next_fault     = fault;
        next_so_q      = so_q;
        next_oe_q      = oe_q;
        next_answer    = answer;
        next_frame_q   = frame_q;
        next_strobe_q  = 1'b0;
        case (state)
            SFC_IDLE: begin
                next_oe_q = 1'b0;
                if (cs_fall && sleep_in) begin
                    next_state = SFC_SLEEP;
                end else if (cs_fall) begin
                    next_state     = SFC_ACTIVE;
                    next_shift     = answer;
                    next_cnt       = CNT_RST;
                    next_seen_rise = 1'b0;
                    next_edge_bad  = pins[1];
                    next_so_q      = fault;
                    next_oe_q      = 1'b1;
                end
            end
            SFC_ACTIVE: begin
                if (sck_rise) begin
                    next_seen_rise = 1'b1;
                    next_so_q      = shift[15];
                end
                if (sck_fall) begin
                    next_shift = {shift[14:0], pins[2]};
                    if (cnt != CNT_MAX) begin
                        next_cnt = cnt + 8'h01;
                    end
                end
                if (cs_rise) begin
                    next_state = SFC_IDLE;
                    next_oe_q  = 1'b0;
                    if (count_ok && !edge_bad && !pins[1]) begin
                        next_frame_q  = shift;
                        next_strobe_q = 1'b1;
                        next_fault    = 1'b0;
                    end else begin
                        next_fault  = 1'b1;
                        next_answer = std_diag;
                        next_answer[FAULT_BIT] = 1'b1;
                    end
                end
            end
            default: begin
                next_oe_q = 1'b0;
                if (cs_rise) begin
                    next_state = SFC_IDLE;
                end
            end
        endcase
        if (strobe_q) begin
            next_answer = reg_hit_in ? {1'b1, reg_data_in} : std_diag;
        end
        if (uv_event_in || spi_reset_in || limp_entry_in) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pins_d    <= PIN_RST;
            state     <= SFC_IDLE;
            shift     <= SHIFT_RST;
            cnt       <= CNT_RST;
            seen_rise <= 1'b0;
            edge_bad  <= 1'b0;
            fault     <= FAULT_RST;
            so_q      <= 1'b0;
            oe_q      <= 1'b0;
            answer    <= SHIFT_RST;
            frame_q   <= SHIFT_RST;
            strobe_q  <= 1'b0;
        end else begin
            pins_d    <= pins;
            state     <= next_state;
            shift     <= next_shift;
            cnt       <= next_cnt;
            seen_rise <= next_seen_rise;
            edge_bad  <= next_edge_bad;
            fault     <= next_fault;
            so_q      <= next_so_q;
            oe_q      <= next_oe_q;
            answer    <= next_answer;
            frame_q   <= next_frame_q;
            strobe_q  <= next_strobe_q;
        end
    end

    assign so_out           = so_q;
    assign so_oe_out        = oe_q;
    assign frame_out        = frame_q;
    assign frame_strobe_out = strobe_q;
    assign fault_flag_out   = fault;

    // ========================================================
    // Checks.
    a_cs_high_off: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state != SFC_ACTIVE) |-> !oe_q)
        else $error("Serial output driven outside a frame.");
    a_sleep_off: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_IDLE && cs_fall && sleep_in) |=> !oe_q [*2])
        else $error("Serial output driven in sleep.");
    a_fall_drive: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_IDLE && cs_fall && !sleep_in)
        |=> oe_q && so_q == $past(fault) && shift == $past(answer))
        else $error("Frame start did not load and drive.");
    a_fault_early: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_ACTIVE && !seen_rise && !sck_rise && !cs_rise)
        |=> so_q == $past(so_q))
        else $error("Output moved before first rising clock.");
    a_rise_msb: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_ACTIVE && sck_rise) |=> so_q == $past(shift[15]))
        else $error("Rising clock did not present the MSB.");
    a_fall_shift: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_ACTIVE && sck_fall && !cs_rise)
        |=> shift[0] == $past(pins[2]) && shift[15:1] == $past(shift[14:0]))
        else $error("Falling clock did not shift in.");
    a_bad_count: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_ACTIVE && cs_rise && !count_ok)
        |=> fault && !strobe_q)
        else $error("Bad frame was not rejected.");
    a_good_commit: assert property (@(posedge mclk_in) disable iff (reset_in)
        (state == SFC_ACTIVE && cs_rise && count_ok && !edge_bad && !pins[1])
        |=> strobe_q && frame_q == $past(shift) ##1 !strobe_q)
        else $error("Valid frame was not committed.");
    a_fault_set: assert property (@(posedge mclk_in) disable iff (reset_in)
        (uv_event_in || spi_reset_in || limp_entry_in) |=> fault)
        else $error("Fault event lost.");
    a_answer_mark: assert property (@(posedge mclk_in) disable iff (reset_in)
        strobe_q |=> answer[REG_MARK] == $past(reg_hit_in)
                     && ($past(reg_hit_in)
                         || answer[FAULT_BIT] == $past(fault)))
        else $error("Answer marker wrong.");
endmodule : sfc_spi_slave
`default_nettype wire

// ### verilog/sfc_pkg.sv
`default_nettype none
package sfc_pkg;
    // ========================================================
    // Frame geometry.
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned CHAIN_STEP = 8;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned FAULT_BIT  = 10;
    localparam int unsigned REG_MARK   = 15;
    // ========================================================
    // Reset values and count limits.
    localparam logic [15:0]      SHIFT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MIN   = 8'h10;
    localparam logic [CNT_W-1:0] CNT_MAX   = 8'hff;
    localparam logic             FAULT_RST = 1'b1;
    localparam logic [2:0]       PIN_RST   = 3'h1;
    // ========================================================
    // Frame states.
    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_ACTIVE,
        SFC_SLEEP
    } sfc_state_t;
endpackage : sfc_pkg
`default_nettype wire

// ### verilog/sfc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_sync #(
    parameter int unsigned WIDTH = 3
) (
    // Clock and reset.
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] rst_val_in,
    // Pins.
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // ========================================================
    // Two flip-flops per pin.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    stage1[i]   <= rst_val_in[i];
                    sync_out[i] <= rst_val_in[i];
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : sfc_sync
`default_nettype wire

// ### tb/sfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_host_model (
    // Clock.
    input  wire logic mclk_in,
    // Serial pins.
    output var  logic chip_select_n_out,
    output var  logic sclk_out,
    output var  logic si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic so_q = 1'b0;
    logic so_line;
    initial begin
        chip_select_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
    end
    // A released line shows the inverse of its last driven level.
    always @(posedge mclk_in) if (so_oe_in) so_q <= so_in;
    assign so_line = so_oe_in ? so_in : ~so_q;
    task automatic half();
        repeat (8) @(posedge mclk_in);
    endtask : half
    task automatic frame(input int nbits, input logic [31:0] tx,
                         output logic [31:0] rx, output logic pre,
                         output logic oe);
        rx = 32'h0;
        chip_select_n_out <= 1'b0;
        half();
        pre = so_line;
        oe = so_oe_in;
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_out <= 1'b1;
            si_out <= tx[i];
            half();
            rx = {rx[30:0], so_line};
            sclk_out <= 1'b0;
            half();
        end
        chip_select_n_out <= 1'b1;
        repeat (70) @(posedge mclk_in);
    endtask : frame
    // Frame whose chip select falls while the serial clock is high.
    task automatic hot_frame();
        sclk_out <= 1'b1;
        half();
        chip_select_n_out <= 1'b0;
        repeat (15) begin
            half();
            sclk_out <= 1'b0;
            half();
            sclk_out <= 1'b1;
        end
        half();
        sclk_out <= 1'b0;
        half();
        chip_select_n_out <= 1'b1;
        repeat (70) @(posedge mclk_in);
    endtask : hot_frame
    task automatic noise();
        repeat (4) begin
            sclk_out <= ~sclk_out;
            si_out <= ~si_out;
            half();
        end
    endtask : noise
endmodule : sfc_host_model
`default_nettype wire

// ### tb/sfc_spi_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_slave_tb;
    import sfc_pkg::*;
    logic mclk = 1'b0, reset, sleep, uv, sres, limp, hit;
    logic cs_n, sclk, si, so, so_oe, strobe, fault;
    logic [15:0] diag, frame, last_frame;
    logic [14:0] rdata;
    logic [31:0] rx;
    logic        pre, oe;
    int bad_count = 0, n_compared = 0, strobes = 0, cycles = 0, s0;
    always #2 mclk = ~mclk;
    sfc_host_model sfc_host_model_inst (.mclk_in(mclk),
        .chip_select_n_out(cs_n), .sclk_out(sclk), .si_out(si),
        .so_in(so), .so_oe_in(so_oe));
    sfc_spi_slave sfc_spi_slave_inst (.mclk_in(mclk), .reset_in(reset),
        .chip_select_n_in(cs_n), .sclk_in(sclk), .si_in(si),
        .so_out(so), .so_oe_out(so_oe), .sleep_in(sleep),
        .uv_event_in(uv), .spi_reset_in(sres), .limp_entry_in(limp),
        .diag_in(diag), .reg_hit_in(hit), .reg_data_in(rdata),
        .frame_out(frame), .frame_strobe_out(strobe),
        .fault_flag_out(fault));
    // ========================================================
    // Monitors and reporting.
    always @(posedge mclk) begin
        if (strobe === 1'b1) begin
            strobes++;
            last_frame = frame;
        end
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] diag_exp(input logic f);
        logic [15:0] d;
        d = diag;
        d[15] = 1'b0;
        d[FAULT_BIT] = f;
        return {16'h0000, d};
    endfunction : diag_exp
    task automatic xfer(input int n, input logic [31:0] tx);
        s0 = strobes;
        sfc_host_model_inst.frame(n, tx, rx, pre, oe);
    endtask : xfer
    // ========================================================
    // Scenarios.
    task automatic t_first();
        check(fault, 1'b1);
        xfer(16, 32'h3c96);
        check(oe, 1'b1);
        check(pre, 1'b1);
        check(32'(strobes - s0), 32'h1);
        check(last_frame, 32'h3c96);
        check(fault, 1'b0);
        check(so_oe, 1'b0);
        $display("test first done");
    endtask : t_first
    task automatic t_hit();
        hit <= 1'b1;
        rdata <= 15'h1234;
        xfer(16, 32'h0155);
        check(rx, diag_exp(1'b0));
        hit <= 1'b0;
        xfer(16, 32'h0a0a);
        check(pre, 1'b0);
        check(rx, {17'h00001, 15'h1234});
        $display("test hit done");
    endtask : t_hit
    task automatic t_chain();
        xfer(24, 32'habcdef);
        check(rx, (diag_exp(1'b0) << 8) | 32'h000000ab);
        check(last_frame, 32'hcdef);
        check(32'(strobes - s0), 32'h1);
        $display("test chain done");
    endtask : t_chain
    task automatic t_bad();
        xfer(17, 32'h1ffff);
        check(32'(strobes - s0), 32'h0);
        check(fault, 1'b1);
        xfer(16, 32'h1234);
        check(pre, 1'b1);
        check(rx, diag_exp(1'b1));
        check(last_frame, 32'h1234);
        s0 = strobes;
        sfc_host_model_inst.hot_frame();
        check(32'(strobes - s0), 32'h0);
        check(fault, 1'b1);
        xfer(16, 32'h0f0f);
        check(rx, diag_exp(1'b1));
        $display("test bad done");
    endtask : t_bad
    task automatic t_events();
        for (int k = 0; k < 3; k++) begin
            {uv, sres, limp} <= 3'b100 >> k;
            @(posedge mclk);
            {uv, sres, limp} <= 3'b000;
            repeat (8) @(posedge mclk);
            check(fault, 1'b1);
            xfer(16, 32'h00f0);
            check(fault, 1'b0);
        end
        $display("test events done");
    endtask : t_events
    task automatic t_quiet();
        s0 = strobes;
        sfc_host_model_inst.noise();
        check(so_oe, 1'b0);
        sleep <= 1'b1;
        xfer(16, 32'h5555);
        check(oe, 1'b0);
        check(32'(strobes - s0), 32'h0);
        sleep <= 1'b0;
        $display("test quiet done");
    endtask : t_quiet
    // ========================================================
    // Main sequence.
    initial begin
        {reset, sleep, uv, sres, limp, hit} = 6'h20;
        diag = 16'hdf5a;
        rdata = 15'h0000;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (8) @(posedge mclk);
        t_first();
        t_hit();
        t_chain();
        t_bad();
        t_events();
        t_quiet();
        summarize();
    end
endmodule : sfc_spi_slave_tb
`default_nettype wire
